// ---- rtl/ssc_pkg.sv ----
// Function
// - Level zero disables, non-zero enables monitoring
// - Monitor active bit is read-only status
// - Level codes select fourteen internal thresholds
// - Code 1111 selects external sense channel
// - Comparator low condition sets the flag
// - Flag with reset enable requests reset
// - Flag stays set until software clears
// - Clear under present low condition sets flag again
// - Zero to non-zero starts blanking delay
// - Monitor active rises after blanking delay
// - Write during blanking aborts the delay
// - Non-zero to non-zero change skips blanking
// - Brownout reset clears register, disables monitor
// - Control register bit layout, two read-only bits
// - Live comparator level readable as status
// - Bit three enables reset on flag
// - Register cleared only by brownout reset
//
// Purpose: Shared constants for the supply supervisor control block.
// Assumes: 50 MHz system clock, byte-wide register port.
// Notes:   Timing counts are derived from times in nanoseconds.

package ssc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] SSC_CTL_ADDR       = 8'h55;
  localparam logic [7:0] SSC_IRQ_STAT_ADDR  = 8'h56;
  localparam logic [7:0] SSC_IRQ_MASK_ADDR  = 8'h57;
  localparam logic [7:0] SSC_CTL_RESET      = 8'h00;
  localparam logic [7:0] SSC_RDATA_UNMAPPED = 8'h00;

  // ==========================================================
  // Control register fields
  localparam int SSC_LVL_MSB      = 7;
  localparam int SSC_LVL_LSB      = 4;
  localparam int SSC_POR_EN_BIT   = 3;
  localparam int SSC_ACTIVE_BIT   = 2;
  localparam int SSC_COMP_BIT     = 1;
  localparam int SSC_FLAG_BIT     = 0;

  localparam logic [3:0] SSC_LVL_OFF    = 4'h0;
  localparam logic [3:0] SSC_LVL_LOWEST = 4'h1;
  localparam logic [3:0] SSC_LVL_2V8    = 4'h8;
  localparam logic [3:0] SSC_LVL_EXT    = 4'hF;

  // ==========================================================
  // Interrupt status and mask fields
  localparam int         SSC_IRQ_W          = 2;
  localparam int         SSC_IRQ_FLAG_BIT   = 0;
  localparam int         SSC_IRQ_ACTIVE_BIT = 1;
  localparam logic [1:0] SSC_IRQ_RESET      = 2'h0;

  // ==========================================================
  // Timing
  localparam int SSC_CLK_HZ       = 50_000_000;
  localparam int SSC_BLANK_NS     = 50_000;
  localparam int SSC_BLANK_CYCLES = (SSC_BLANK_NS * (SSC_CLK_HZ / 1_000_000)) / 1000;
  localparam int SSC_CNT_W        = 12;

  // ==========================================================
  // Supervisor states
  typedef enum logic [1:0] {
    SSC_ST_OFF    = 2'b00,
    SSC_ST_BLANK  = 2'b01,
    SSC_ST_ACTIVE = 2'b10
  } ssc_state_e;

endpackage

// ---- rtl/ssc_supervisor.sv ----
// Purpose: Control, status and reset request logic of a supply supervisor.
// Assumes: reset_n_i is the brownout reset; the comparator is asynchronous.
// Notes:   comp_low_i high means the monitored voltage is below threshold.

`timescale 1ns/1ns
`default_nettype none

module ssc_supervisor
  import ssc_pkg::*;
#(
  parameter int BLANK_CYCLES = SSC_BLANK_CYCLES
) (
  // Clock and brownout reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output var  logic [7:0] reg_rdata_o,
  // Analog comparator side
  input  wire logic       comp_low_i,
  output var  logic       monitor_enable_o,
  output var  logic [3:0] threshold_level_o,
  output var  logic       ext_sense_select_o,
  // Reset generator and interrupt
  output var  logic       por_request_o,
  output var  logic       irq_o
);

  // ==========================================================
  // Registers
  logic [3:0]           ctl_level;
  logic                 ctl_por_en;
  logic                 ctl_flag;
  ssc_state_e           state;
  logic [SSC_CNT_W-1:0] blank_cnt;
  logic                 comp_meta;
  logic                 comp_sync;
  logic [SSC_IRQ_W-1:0] irq_stat;
  logic [SSC_IRQ_W-1:0] irq_mask;

  // ==========================================================
  // Address decode
  wire ctl_wr   = reg_wr_i && (reg_addr_i == SSC_CTL_ADDR);
  wire mask_wr  = reg_wr_i && (reg_addr_i == SSC_IRQ_MASK_ADDR);
  wire stat_rd  = reg_rd_i && (reg_addr_i == SSC_IRQ_STAT_ADDR);
  wire [3:0] wr_level = reg_wdata_i[SSC_LVL_MSB:SSC_LVL_LSB];
  wire       wr_on    = (wr_level != SSC_LVL_OFF);

  // ==========================================================
  // Supervisor state machine
  wire active    = (state == SSC_ST_ACTIVE);
  wire blank_end = (state == SSC_ST_BLANK) && (blank_cnt == '0);
  ssc_state_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      SSC_ST_OFF: begin
        if (ctl_wr && wr_on) begin
          next_state = SSC_ST_BLANK;
        end
      end
      SSC_ST_BLANK: begin
        if (ctl_wr) begin
          // Aborting skips analog settling; results may be unreliable
          next_state = wr_on ? SSC_ST_ACTIVE : SSC_ST_OFF;
        end else if (blank_cnt == '0) begin
          next_state = SSC_ST_ACTIVE;
        end
      end
      SSC_ST_ACTIVE: begin
        // Level to level stays live; no blanking on this path
        if (ctl_wr && !wr_on) begin
          next_state = SSC_ST_OFF;
        end
      end
      default: begin
        next_state = SSC_ST_OFF;
      end
    endcase
  end

  wire [SSC_CNT_W-1:0] blank_load = SSC_CNT_W'(BLANK_CYCLES - 1);
  wire [SSC_CNT_W-1:0] next_blank_cnt =
    (state == SSC_ST_OFF) ? blank_load :
    (blank_cnt != '0)     ? blank_cnt - SSC_CNT_W'(1) : blank_cnt;

  // ==========================================================
  // Flag, control fields and reset request
  wire set_cond  = active && comp_sync && (next_state == SSC_ST_ACTIVE);
  wire next_flag = set_cond || (ctl_wr ? reg_wdata_i[SSC_FLAG_BIT] : ctl_flag);
  wire [3:0] next_level  = ctl_wr ? wr_level : ctl_level;
  wire       next_por_en = ctl_wr ? reg_wdata_i[SSC_POR_EN_BIT] : ctl_por_en;
  // Reset generation is suppressed outside active monitoring
  wire next_por = next_flag && next_por_en && (next_state == SSC_ST_ACTIVE);

  // ==========================================================
  // Interrupt events: flag set by a low condition, monitoring becoming valid
  wire [SSC_IRQ_W-1:0] irq_event;
  assign irq_event[SSC_IRQ_FLAG_BIT]   = set_cond && !ctl_flag;
  assign irq_event[SSC_IRQ_ACTIVE_BIT] = !active && (next_state == SSC_ST_ACTIVE);
  // Set wins over the read-clear in the same cycle
  wire [SSC_IRQ_W-1:0] next_irq_stat = irq_event | (stat_rd ? '0 : irq_stat);
  wire [SSC_IRQ_W-1:0] next_irq_mask = mask_wr ? reg_wdata_i[SSC_IRQ_W-1:0] : irq_mask;

  // ==========================================================
  // Read mux
  wire [7:0] ctl_rd_val = {ctl_level, ctl_por_en, active, comp_sync, ctl_flag};
  wire [7:0] next_rdata =
    !reg_rd_i                           ? SSC_RDATA_UNMAPPED :
    (reg_addr_i == SSC_CTL_ADDR)        ? ctl_rd_val :
    (reg_addr_i == SSC_IRQ_STAT_ADDR)   ? {6'h00, irq_stat} :
    (reg_addr_i == SSC_IRQ_MASK_ADDR)   ? {6'h00, irq_mask} : SSC_RDATA_UNMAPPED;

  // ==========================================================
  // Comparator synchroniser
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_low_i;
      comp_sync <= comp_meta;
    end
  end

  // ==========================================================
  // Only the brownout reset clears these; no other reset reaches them
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_level  <= SSC_CTL_RESET[SSC_LVL_MSB:SSC_LVL_LSB];
      ctl_por_en <= SSC_CTL_RESET[SSC_POR_EN_BIT];
      ctl_flag   <= SSC_CTL_RESET[SSC_FLAG_BIT];
      state      <= SSC_ST_OFF;
      blank_cnt  <= '0;
    end else begin
      ctl_level  <= next_level;
      ctl_por_en <= next_por_en;
      ctl_flag   <= next_flag;
      state      <= next_state;
      blank_cnt  <= next_blank_cnt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat <= SSC_IRQ_RESET;
      irq_mask <= SSC_IRQ_RESET;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // ==========================================================
  // Output flops
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o        <= SSC_RDATA_UNMAPPED;
      monitor_enable_o   <= 1'b0;
      threshold_level_o  <= SSC_LVL_OFF;
      ext_sense_select_o <= 1'b0;
      por_request_o      <= 1'b0;
      irq_o              <= 1'b0;
    end else begin
      reg_rdata_o        <= next_rdata;
      monitor_enable_o   <= (next_level != SSC_LVL_OFF);
      threshold_level_o  <= next_level;
      ext_sense_select_o <= (next_level == SSC_LVL_EXT);
      por_request_o      <= next_por;
      irq_o              <= |(next_irq_stat & next_irq_mask);
    end
  end

  // ==========================================================
  // Assertions
  sequence s_turn_on;
    (state == SSC_ST_OFF) && ctl_wr && wr_on;
  endsequence

  sequence s_quiet_blank;
    (state == SSC_ST_BLANK) && !ctl_wr;
  endsequence

  sequence s_ctl_read;
    reg_rd_i && (reg_addr_i == SSC_CTL_ADDR);
  endsequence

  sequence s_flag_clear;
    ctl_wr && !reg_wdata_i[SSC_FLAG_BIT] && !set_cond;
  endsequence

  a_off_when_zero: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ctl_wr && !wr_on |=> (state == SSC_ST_OFF) && !monitor_enable_o && !ctl_rd_val[2])
    else $error("Supervisor not off after zero level write");

  a_active_ro_bit: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ctl_wr && !wr_on && reg_wdata_i[SSC_ACTIVE_BIT] |=> !active ##1 !active)
    else $error("Writing active bit switched the supervisor on");

  a_level_routed: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ctl_wr |=> (threshold_level_o == $past(wr_level)))
    else $error("Threshold level output does not follow write");

  a_ext_channel: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ext_sense_select_o == (ctl_level == SSC_LVL_EXT))
    else $error("External channel select wrong");

  a_flag_sets: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    active && comp_sync && !ctl_wr |=> ctl_flag)
    else $error("Low condition did not set flag");

  a_por_from_flag: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    por_request_o == (ctl_flag && ctl_por_en && active))
    else $error("Reset request does not match flag and enable");

  a_flag_holds: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ctl_flag && !ctl_wr |=> ctl_flag)
    else $error("Flag dropped without software clear");

  a_flag_reasserts: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    active && comp_sync && ctl_wr && wr_on && !reg_wdata_i[SSC_FLAG_BIT] |=> ctl_flag)
    else $error("Flag not set again under present low condition");

  a_blank_start: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_turn_on |=> (state == SSC_ST_BLANK) && !por_request_o)
    else $error("Blanking delay did not start");

  a_blank_quiet: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_quiet_blank ##0 !blank_end |=> $stable(ctl_flag) && !por_request_o)
    else $error("Flag or reset changed during blanking");

  a_blank_ends: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    blank_end && !ctl_wr |=> active ##0 irq_stat[SSC_IRQ_ACTIVE_BIT])
    else $error("Monitor not active when blanking elapsed");

  a_blank_count: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == SSC_ST_BLANK) |-> (blank_cnt <= SSC_CNT_W'(BLANK_CYCLES - 1)))
    else $error("Blanking counter beyond delay");

  a_abort_blank: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == SSC_ST_BLANK) && ctl_wr && wr_on |=> active)
    else $error("Write did not abort blanking");

  a_no_reblank: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    active && ctl_wr && wr_on |=> active)
    else $error("Level change re-entered blanking");

  a_comp_status: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    reg_rd_i && (reg_addr_i == SSC_CTL_ADDR) |=> reg_rdata_o[SSC_COMP_BIT] == $past(comp_sync))
    else $error("Comparator status bit wrong");

  // Assumes the blanking delay is at least two cycles long
  a_blank_holds: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_turn_on ##1 s_quiet_blank |=> !active)
    else $error("Monitor active too early in blanking");

  a_por_off_quiet: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state != SSC_ST_ACTIVE) |-> !por_request_o)
    else $error("Reset request outside active monitoring");

  a_off_steady: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == SSC_ST_OFF) && !ctl_wr |=> $stable(ctl_flag))
    else $error("Flag changed while supervisor off");

  a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_flag_clear |=> !ctl_flag)
    else $error("Software clear of flag lost");

  a_mon_enable: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    monitor_enable_o == (ctl_level != SSC_LVL_OFF))
    else $error("Monitor enable does not follow level");

  a_level_mirror: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    threshold_level_o == ctl_level)
    else $error("Threshold output differs from level field");

  a_por_en_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ctl_wr |=> ctl_por_en == $past(reg_wdata_i[SSC_POR_EN_BIT]))
    else $error("Reset enable bit not written");

  a_no_sw_change: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !ctl_wr |=> $stable(ctl_level) && $stable(ctl_por_en))
    else $error("Control fields changed without a write");

  // ==========================================================
  // Synchroniser, blanking counter and interrupt event checks
  a_sync_pipe: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    comp_sync == $past(comp_meta))
    else $error("Comparator synchroniser skipped a stage");

  a_blank_load: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == SSC_ST_OFF) |=> blank_cnt == SSC_CNT_W'(BLANK_CYCLES - 1))
    else $error("Blanking counter not loaded while off");

  a_cnt_down: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == SSC_ST_BLANK) && (blank_cnt != '0) |=>
      blank_cnt == $past(blank_cnt) - SSC_CNT_W'(1))
    else $error("Blanking counter did not count down");

  a_active_irq: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(active) |-> irq_stat[SSC_IRQ_ACTIVE_BIT])
    else $error("Monitoring valid event not recorded");

  a_flag_irq: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(ctl_flag) && $past(set_cond) |-> irq_stat[SSC_IRQ_FLAG_BIT])
    else $error("Flag event not recorded");

  // ==========================================================
  // Register port and interrupt checks
  a_ctl_readback: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_ctl_read |=> reg_rdata_o == $past(ctl_rd_val))
    else $error("Control register read back wrong");

  a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !reg_rd_i |=> reg_rdata_o == SSC_RDATA_UNMAPPED)
    else $error("Read data not idle outside read cycle");

  a_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    reg_rd_i && (reg_addr_i != SSC_CTL_ADDR) && (reg_addr_i != SSC_IRQ_STAT_ADDR) &&
      (reg_addr_i != SSC_IRQ_MASK_ADDR) |=> reg_rdata_o == SSC_RDATA_UNMAPPED)
    else $error("Unmapped read returned data");

  a_mask_readback: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    reg_rd_i && (reg_addr_i == SSC_IRQ_MASK_ADDR) |=>
      reg_rdata_o == {6'h00, $past(irq_mask)})
    else $error("Mask register read back wrong");

  a_mask_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    mask_wr |=> irq_mask == $past(reg_wdata_i[SSC_IRQ_W-1:0]))
    else $error("Mask register not written");

  a_stat_clear: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    stat_rd && (irq_event == '0) |=> irq_stat == '0)
    else $error("Status read did not clear events");

  a_stat_sticky: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !stat_rd |=> ($past(irq_stat) & ~irq_stat) == '0)
    else $error("Status bit dropped without a read");

  a_irq_level: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    irq_o == |(irq_stat & irq_mask))
    else $error("Interrupt output does not match status and mask");

endmodule

`default_nettype wire

// ---- tb/ssc_comp_model.sv ----
// Purpose: Behavioural model of the analog comparator and the reset generator.
// Assumes: Supply and external levels are given as below/above flags by the bench.
// Notes:   Output is high while the monitored voltage is below threshold.

`timescale 1ns/1ns
`default_nettype none

module ssc_comp_model (
  // Supervisor control side
  input  wire logic       monitor_enable_i,
  input  wire logic [3:0] threshold_level_i,
  input  wire logic       ext_sense_select_i,
  input  wire logic       por_request_i,
  // Stimulus from the bench
  input  wire logic       supply_below_i,
  input  wire logic       ext_below_i,
  // Comparator output and reset count
  output var  logic       comp_low_o,
  output var  int         por_count_o
);
  // ==========================================================
  // Comparator
  // A powered-down comparator reads low, never the last value
  assign comp_low_o = monitor_enable_i && (threshold_level_i != 4'h0) &&
                      (ext_sense_select_i ? ext_below_i : supply_below_i);

  // ==========================================================
  // Reset generator
  initial por_count_o = 0;
  always @(posedge por_request_i) begin
    por_count_o = por_count_o + 1;
  end
endmodule

`default_nettype wire

// ---- tb/tb_supply_supervisor_control.sv ----
// Purpose: Self-checking bench of the supply supervisor control block.
// Assumes: Blanking shortened to 8 cycles; 50 MHz clock.
// Notes:   Random levels use a fixed seed, so runs repeat.

`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_supply_supervisor_control
  import ssc_pkg::*;
;
  localparam int BLANK = 8;
  logic       sys_clk_i, reset_n_i, reg_wr_i, reg_rd_i, sup_below, ext_below;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic       comp_low, mon_en, ext_sel, por_req, irq;
  logic [3:0] lvl;
  logic [3:0] code;
  int         por_count, n_mismatch, n_compared, seed;

  ssc_supervisor #(.BLANK_CYCLES(BLANK)) i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .comp_low_i(comp_low),
    .monitor_enable_o(mon_en), .threshold_level_o(lvl), .ext_sense_select_o(ext_sel),
    .por_request_o(por_req), .irq_o(irq));

  ssc_comp_model i_comp (.monitor_enable_i(mon_en), .threshold_level_i(lvl),
    .ext_sense_select_i(ext_sel), .por_request_i(por_req), .supply_below_i(sup_below),
    .ext_below_i(ext_below), .comp_low_o(comp_low), .por_count_o(por_count));

  // ==========================================================
  // Bus tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    cyc(1);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    cyc(1);
    reg_rd_i   <= 1'b0;
    `CHK(reg_rdata_o & m, e & m)
  endtask

  task automatic give_verdict;
    $display("Counts: compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, reset and watchdog
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #(20 * 20000);
    n_mismatch++;
    give_verdict;
  end

  // ==========================================================
  // Main sequence
  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, sup_below, ext_below} = '0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    n_mismatch = 0;
    n_compared = 0;
    seed = 96;
    cyc(12);
    reset_n_i <= 1'b1;
    `CHK({mon_en, ext_sel, por_req, irq, lvl}, 8'h00)
    rd_chk(SSC_CTL_ADDR, 8'h00, 8'hFF);
    wr_reg(8'h33, 8'hFF);
    rd_chk(8'h33, 8'h00, 8'hFF);
    wr_reg(SSC_CTL_ADDR, 8'h06);
    rd_chk(SSC_CTL_ADDR, 8'h00, 8'hFF);
    $display("Test reset and read-only bits done");
    // Blanking from off, then flag with reset request
    sup_below <= 1'b1;
    wr_reg(SSC_CTL_ADDR, 8'h18);
    `CHK({mon_en, lvl}, 5'h11)
    cyc(3);
    `CHK(por_req, 1'b0)
    rd_chk(SSC_CTL_ADDR, 8'h18, 8'hFD);
    cyc(BLANK + 3);
    `CHK(por_req, 1'b1)
    `CHK(por_count, 1)
    rd_chk(SSC_CTL_ADDR, 8'h1F, 8'hFF);
    sup_below <= 1'b0;
    cyc(5);
    rd_chk(SSC_CTL_ADDR, 8'h1D, 8'hFF);
    wr_reg(SSC_CTL_ADDR, 8'h18);
    rd_chk(SSC_CTL_ADDR, 8'h1C, 8'hFF);
    sup_below <= 1'b1;
    cyc(5);
    wr_reg(SSC_CTL_ADDR, 8'h18);
    rd_chk(SSC_CTL_ADDR, 8'h1F, 8'hFF);
    $display("Test blanking and flag done");
    // Level change while active: no blanking, reset disabled
    sup_below <= 1'b0;
    cyc(3);
    wr_reg(SSC_CTL_ADDR, 8'h90);
    rd_chk(SSC_CTL_ADDR, 8'h94, 8'hFF);
    sup_below <= 1'b1;
    cyc(4);
    rd_chk(SSC_CTL_ADDR, 8'h97, 8'hFF);
    `CHK(por_req, 1'b0)
    // Abort of blanking by a second write, external channel
    sup_below <= 1'b0;
    ext_below <= 1'b1;
    wr_reg(SSC_CTL_ADDR, 8'h00);
    `CHK(mon_en, 1'b0)
    wr_reg(SSC_CTL_ADDR, 8'hF0);
    wr_reg(SSC_CTL_ADDR, 8'hF0);
    `CHK(ext_sel, 1'b1)
    cyc(3);
    rd_chk(SSC_CTL_ADDR, 8'hF7, 8'hFF);
    $display("Test level change and abort done");
    // Every non-zero level code, then random ones
    ext_below <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      code = (i < 15) ? 4'(i + 1) : 4'(($random(seed) & 32'hF) % 15 + 1);
      wr_reg(SSC_CTL_ADDR, {code, 1'($random(seed)), 3'h0});
      `CHK({mon_en, ext_sel, lvl}, {1'b1, code == SSC_LVL_EXT, code})
    end
    $display("Test level codes done");
    // Interrupt raise, read-clear and mask
    wr_reg(SSC_CTL_ADDR, 8'h00);
    rd_chk(SSC_IRQ_STAT_ADDR, 8'h03, 8'hFF);
    wr_reg(SSC_IRQ_MASK_ADDR, 8'h03);
    rd_chk(SSC_IRQ_MASK_ADDR, 8'h03, 8'hFF);
    sup_below <= 1'b1;
    wr_reg(SSC_CTL_ADDR, 8'h10);
    cyc(BLANK + 6);
    `CHK(irq, 1'b1)
    rd_chk(SSC_IRQ_STAT_ADDR, 8'h03, 8'hFF);
    cyc(2);
    `CHK(irq, 1'b0)
    sup_below <= 1'b0;
    wr_reg(SSC_IRQ_MASK_ADDR, 8'h00);
    wr_reg(SSC_CTL_ADDR, 8'h10);
    sup_below <= 1'b1;
    cyc(6);
    `CHK(irq, 1'b0)
    wr_reg(SSC_IRQ_MASK_ADDR, 8'h01);
    cyc(2);
    `CHK(irq, 1'b1)
    $display("Test interrupt done");
    // Brownout in mid-run clears everything
    reset_n_i <= 1'b0;
    cyc(2);
    reset_n_i <= 1'b1;
    `CHK({mon_en, por_req, irq}, 3'h0)
    rd_chk(SSC_CTL_ADDR, 8'h00, 8'hFF);
    $display("Test brownout done");
    give_verdict;
  end
endmodule

`default_nettype wire
